// ===== rtl/ptm_timer.sv
// 10-bit periodic timer with axi4-lite register access
`include "ptm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ptm_timer #(
	parameter int CNT_W = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// prescaled clock enables from the clock unit
	input wire logic high_clk_tick,
	input wire logic sub_clk_tick,
	// pins
	input wire logic external_clock_pin,
	input wire logic timer_io_pin_in,
	output logic timer_io_pin_out,
	output logic timer_io_pin_oe,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output ptm_pkg::ptm_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output ptm_pkg::ptm_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ptm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] clk_run_ff;
	logic [7:0] mode_out_ff;
	logic [CNT_W-1:0] cmpa_ff;
	logic [CNT_W-1:0] cmpp_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic run_d_ff;
	logic out_ff;
	logic nxt_out;
	logic [2:0] ck_sync_ff;
	logic [2:0] io_sync_ff;
	logic ck_lvl_ff;
	logic io_lvl_ff;
	logic [5:0] pre_sys_ff;
	logic [5:0] pre_h_ff;

	wire pause = clk_run_ff[`PTM_BIT_PAUSE];
	wire [2:0] ck_sel = clk_run_ff[`PTM_BIT_CKSEL_HI:`PTM_BIT_CKSEL_LO];
	wire run = clk_run_ff[`PTM_BIT_RUN];
	wire [1:0] iof = mode_out_ff[`PTM_BIT_IOF_HI:`PTM_BIT_IOF_LO];
	wire init_lvl = mode_out_ff[`PTM_BIT_INIT];
	wire inv = mode_out_ff[`PTM_BIT_INV];
	wire cap_src = mode_out_ff[`PTM_BIT_CAPSRC];
	wire clr_sel = mode_out_ff[`PTM_BIT_CLRSEL];
	ptm_mode_t mode;
	assign mode = ptm_mode_t'(mode_out_ff[`PTM_BIT_MODE_HI:`PTM_BIT_MODE_LO]);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and clock sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_sync_ff <= 3'h0;
			io_sync_ff <= 3'h0;
			ck_lvl_ff <= 1'b0;
			io_lvl_ff <= 1'b0;
		end else begin
			ck_sync_ff <= {ck_sync_ff[1:0], external_clock_pin};
			io_sync_ff <= {io_sync_ff[1:0], timer_io_pin_in};
			if (ck_sync_ff[2] == ck_sync_ff[1])
				ck_lvl_ff <= ck_sync_ff[2];
			if (io_sync_ff[2] == io_sync_ff[1])
				io_lvl_ff <= io_sync_ff[2];
		end
	end

	// a level change is taken only once stages two and three agree
	wire ck_new = (ck_sync_ff[2] == ck_sync_ff[1]) ? ck_sync_ff[2] : ck_lvl_ff;
	wire io_new = (io_sync_ff[2] == io_sync_ff[1]) ? io_sync_ff[2] : io_lvl_ff;
	wire ck_rise = ck_new & ~ck_lvl_ff;
	wire ck_fall = ~ck_new & ck_lvl_ff;
	wire io_rise = io_new & ~io_lvl_ff;
	wire io_fall = ~io_new & io_lvl_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_sys_ff <= 6'h00;
			pre_h_ff <= 6'h00;
		end else begin
			pre_sys_ff <= pre_sys_ff + 6'h01;
			if (high_clk_tick)
				pre_h_ff <= pre_h_ff + 6'h01;
		end
	end

	wire sys4_tick = (pre_sys_ff[1:0] == 2'(`PTM_DIV_SYS4 - 1));
	wire h16_tick = high_clk_tick & (pre_h_ff[3:0] == 4'(`PTM_DIV_H16 - 1));
	wire h64_tick = high_clk_tick & (pre_h_ff == 6'(`PTM_DIV_H64 - 1));

	logic tick;
	always_comb begin
		unique case (ck_sel)
			3'h0: tick = sys4_tick;
			3'h1: tick = 1'b1;
			3'h2: tick = h16_tick;
			3'h3: tick = h64_tick;
			3'h4, 3'h5: tick = sub_clk_tick;
			3'h6: tick = ck_rise;
			3'h7: tick = ck_fall;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// counter and comparators
	wire run_rise = run & ~run_d_ff;
	wire match_a = (cnt_ff == cmpa_ff);
	wire match_p = (cnt_ff == cmpp_ff);
	wire p_zero = (cmpp_ff == '0);
	wire cnt_max = (cnt_ff == '1);
	// pwm period is exactly the compare p value: clear on the count before it,
	// which wraps to the top count when p is zero and gives the full period
	wire p_last = (cnt_ff == (cmpp_ff - 1'b1));
	wire step = run & ~pause & tick;
	wire pulse_mode = (mode == PTM_MODE_PWM) && (iof == 2'h3);

	logic clr_hit;
	always_comb begin
		if ((mode == PTM_MODE_CMP || mode == PTM_MODE_TMR) && clr_sel)
			clr_hit = match_a;
		else if (pulse_mode)
			clr_hit = 1'b0;
		else if (mode == PTM_MODE_PWM)
			clr_hit = p_last;
		else if (p_zero)
			clr_hit = cnt_max;
		else
			clr_hit = match_p;
	end

	// a single pulse ends on a compare a match and drops the run bit
	wire pulse_end = pulse_mode & step & match_a & ~run_rise;
	// in single pulse mode a rising clock pin edge also starts the pulse
	wire pin_start = pulse_mode & ~run & ck_rise;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (run_rise)
			nxt_cnt = '0;
		else if (step)
			nxt_cnt = clr_hit ? '0 : cnt_ff + 1'b1;
	end

	wire cap_rise = cap_src ? ck_rise : io_rise;
	wire cap_fall = cap_src ? ck_fall : io_fall;
	wire cap_hit = (mode == PTM_MODE_CAP) && run &&
		((iof == 2'h0 && cap_rise) || (iof == 2'h1 && cap_fall) ||
		(iof == 2'h2 && (cap_rise || cap_fall)));

	////////////////////////////////////////////////////////////////////////////
	// output logic
	// duty at or past the period gives full duty
	wire [CNT_W:0] period = p_zero ? (CNT_W+1)'(1 << CNT_W) : {1'b0, cmpp_ff};
	wire pwm_act = ({1'b0, cnt_ff} < {1'b0, cmpa_ff}) || ({1'b0, cmpa_ff} >= period);

	always_comb begin
		nxt_out = out_ff;
		if (run_rise && mode != PTM_MODE_CAP)
			nxt_out = init_lvl;
		else if (mode == PTM_MODE_CMP && step && match_a) begin
			unique case (iof)
				2'h0: nxt_out = out_ff;
				2'h1: nxt_out = 1'b0;
				2'h2: nxt_out = 1'b1;
				2'h3: nxt_out = ~out_ff;
			endcase
		end else if (mode == PTM_MODE_PWM) begin
			// pwm field, active level from initial bit
			unique case (iof)
				2'h0: nxt_out = ~init_lvl;
				2'h1: nxt_out = init_lvl;
				2'h2: nxt_out = run ? (pwm_act ? init_lvl : ~init_lvl) : out_ff;
				2'h3: nxt_out = (pulse_end | ~run) ? ~init_lvl : init_lvl;
			endcase
		end
	end

	// invert; timer mode leaves the pin alone
	assign timer_io_pin_out = out_ff ^ inv;
	assign timer_io_pin_oe = (mode == PTM_MODE_CMP) || (mode == PTM_MODE_PWM);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
			run_d_ff <= 1'b0;
			out_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			run_d_ff <= run;
			out_ff <= nxt_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic aw_ok_ff;
	logic w_ok_ff;
	logic [7:0] awaddr_ff;
	logic [7:0] wbyte_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	logic bad_w_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic bad_r_ff;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a[1:0] == 2'h0) && (a <= `PTM_OFF_CMPP_HI);
	endfunction

	assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_ok_ff & ~bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bad_w_ff ? PTM_RESP_SLVERR : PTM_RESP_OKAY;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = bad_r_ff ? PTM_RESP_SLVERR : PTM_RESP_OKAY;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire have_aw = aw_ok_ff | aw_take;
	wire have_w = w_ok_ff | w_take;
	wire [7:0] wa = aw_ok_ff ? awaddr_ff : s_axi_awaddr;
	wire [7:0] wd = w_ok_ff ? wbyte_ff : s_axi_wdata[7:0];
	wire ws = w_ok_ff ? wstrb0_ff : s_axi_wstrb[0];
	wire do_wr = have_aw & have_w & ~bvalid_ff;
	wire wr_en = do_wr & ws & addr_known(wa);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wbyte_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bad_w_ff <= 1'b0;
		end else begin
			if (aw_take)
				awaddr_ff <= s_axi_awaddr;
			if (w_take) begin
				wbyte_ff <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
			aw_ok_ff <= have_aw & ~do_wr;
			w_ok_ff <= have_w & ~do_wr;
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bad_w_ff <= ~addr_known(wa);
			end else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// writable fields; reserved bits stay zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_run_ff <= `PTM_RST_REG;
			mode_out_ff <= `PTM_RST_REG;
			cmpa_ff <= '0;
			cmpp_ff <= '0;
		end else begin
			if (wr_en && wa == `PTM_OFF_CLK_RUN)
				clk_run_ff <= {wd[7:3], 3'h0};
			else if (pulse_end)
				clk_run_ff[`PTM_BIT_RUN] <= 1'b0;
			else if (pin_start)
				clk_run_ff[`PTM_BIT_RUN] <= 1'b1;
			if (wr_en && wa == `PTM_OFF_MODE_OUT)
				mode_out_ff <= wd;
			if (wr_en && wa == `PTM_OFF_CMPA_LO)
				cmpa_ff[7:0] <= wd;
			else if (wr_en && wa == `PTM_OFF_CMPA_HI)
				cmpa_ff[CNT_W-1:8] <= wd[CNT_W-9:0];
			else if (cap_hit)
				cmpa_ff <= cnt_ff;
			if (wr_en && wa == `PTM_OFF_CMPP_LO)
				cmpp_ff[7:0] <= wd;
			else if (wr_en && wa == `PTM_OFF_CMPP_HI)
				cmpp_ff[CNT_W-1:8] <= wd[CNT_W-9:0];
		end
	end

	logic [7:0] rd_byte;
	always_comb begin
		unique case (s_axi_araddr)
			`PTM_OFF_CLK_RUN: rd_byte = clk_run_ff;
			`PTM_OFF_MODE_OUT: rd_byte = mode_out_ff;
			`PTM_OFF_CNT_LO: rd_byte = cnt_ff[7:0];
			`PTM_OFF_CNT_HI: rd_byte = 8'({cnt_ff[CNT_W-1:8]});
			`PTM_OFF_CMPA_LO: rd_byte = cmpa_ff[7:0];
			`PTM_OFF_CMPA_HI: rd_byte = 8'({cmpa_ff[CNT_W-1:8]});
			`PTM_OFF_CMPP_LO: rd_byte = cmpp_ff[7:0];
			`PTM_OFF_CMPP_HI: rd_byte = 8'({cmpp_ff[CNT_W-1:8]});
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			bad_r_ff <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte};
			bad_r_ff <= ~addr_known(s_axi_araddr);
		end else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end
endmodule : ptm_timer
`default_nettype wire

// ===== rtl/ptm_cfg.svh
// register offsets, field positions, reset values and clock divides for the periodic timer
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
`define PTM_OFF_CLK_RUN 8'h00
`define PTM_OFF_MODE_OUT 8'h04
`define PTM_OFF_CNT_LO 8'h08
`define PTM_OFF_CNT_HI 8'h0C
`define PTM_OFF_CMPA_LO 8'h10
`define PTM_OFF_CMPA_HI 8'h14
`define PTM_OFF_CMPP_LO 8'h18
`define PTM_OFF_CMPP_HI 8'h1C
`define PTM_BIT_PAUSE 7
`define PTM_BIT_CKSEL_HI 6
`define PTM_BIT_CKSEL_LO 4
`define PTM_BIT_RUN 3
`define PTM_BIT_MODE_HI 7
`define PTM_BIT_MODE_LO 6
`define PTM_BIT_IOF_HI 5
`define PTM_BIT_IOF_LO 4
`define PTM_BIT_INIT 3
`define PTM_BIT_INV 2
`define PTM_BIT_CAPSRC 1
`define PTM_BIT_CLRSEL 0
`define PTM_RST_REG 8'h00
`define PTM_DIV_SYS4 4
`define PTM_DIV_H16 16
`define PTM_DIV_H64 64
`endif

// ===== rtl/ptm_pkg.sv
// types shared by the periodic timer design
package ptm_pkg;
	typedef enum logic [1:0] {
		PTM_MODE_CMP,
		PTM_MODE_CAP,
		PTM_MODE_PWM,
		PTM_MODE_TMR
	} ptm_mode_t;
	typedef enum logic [1:0] {
		PTM_RESP_OKAY = 2'h0,
		PTM_RESP_SLVERR = 2'h2
	} ptm_resp_t;
endpackage : ptm_pkg

// ===== tb/ptm_timer_asserts.sv
// bus handshake and read-data checker for the periodic timer
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_chk
	import ptm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire ptm_pkg::ptm_resp_t s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	r_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	run_low_zero_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=> s_axi_rdata[2:0] == 3'h0)
		else $error("unused control bits not zero");
	high_zero_a: assert property (s_axi_arvalid && s_axi_arready &&
		(s_axi_araddr inside {8'h0C, 8'h14, 8'h1C}) |=> s_axi_rdata[31:2] == 30'h0)
		else $error("high byte upper bits not zero");
	unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
		|=> s_axi_rresp == PTM_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read accepted");
endmodule : ptm_timer_chk
bind ptm_timer ptm_timer_chk chk_u (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire

// ===== tb/ptm_timer_tb.sv
// self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
`include "ptm_cfg.svh"
module ptm_timer_tb;
	import ptm_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic high_clk_tick = 1'h0;
	logic sub_clk_tick = 1'h0;
	logic external_clock_pin = 1'h0;
	logic timer_io_pin_in = 1'h0;
	logic timer_io_pin_out, timer_io_pin_oe;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, rd_d, v;
	ptm_resp_t s_axi_bresp, s_axi_rresp, br, rr;
	int err_count = 0;
	int samples_checked = 0;
	int h = 0;
	logic [7:0] md [6] = '{8'h21, 8'h11, 8'h38, 8'h09, 8'h88, 8'h98};
	logic [1:0] pb [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3};
	logic [1:0] pa [6] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
	ptm_timer dut_u (.clk, .rst, .high_clk_tick, .sub_clk_tick, .external_clock_pin,
		.timer_io_pin_in, .timer_io_pin_out, .timer_io_pin_oe, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	initial forever #50 clk = ~clk;
	////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t ns: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// each task that drives the bus or pins opens on an edge so back-to-back calls never drive a signal twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			n++;
		end while (s_axi_bvalid !== 1'h1 && n < 99);
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n >= 99) chk(32'h0, 32'h1);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			n++;
		end while (s_axi_rvalid !== 1'h1 && n < 99);
		rd_d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n >= 99) chk(32'h0, 32'h1);
	endtask : rd
	task automatic po(input logic [1:0] e);
		repeat (2) @(posedge clk);
		chk({30'h0, timer_io_pin_oe, timer_io_pin_out}, {30'h0, e});
	endtask : po
	task automatic pulses(input int k);
		repeat (k) begin
			repeat (8) @(posedge clk);
			external_clock_pin <= 1'h1;
			repeat (8) @(posedge clk);
			external_clock_pin <= 1'h0;
		end
		repeat (8) @(posedge clk);
	endtask : pulses
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4));
			chk(rd_d, 32'h0);
		end
		rd(8'h20);
		chk(32'(rr), 32'(PTM_RESP_SLVERR));
		wr(8'h24, 8'h5A);
		chk(32'(br), 32'(PTM_RESP_SLVERR));
		wr(`PTM_OFF_CMPA_HI, 8'hFF);
		rd(`PTM_OFF_CMPA_HI);
		chk(rd_d, 32'h3);
		wr(`PTM_OFF_CLK_RUN, 8'hFF);
		rd(`PTM_OFF_CLK_RUN);
		chk(rd_d, 32'hF8);
		wr(`PTM_OFF_CNT_LO, 8'h55);
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, 32'h0);
		wr(`PTM_OFF_CLK_RUN, 8'h18);
		rd(`PTM_OFF_CNT_LO);
		v = rd_d;
		rd(`PTM_OFF_CNT_LO);
		chk({31'h0, rd_d > v}, 32'h1);
		wr(`PTM_OFF_CLK_RUN, 8'h98);
		rd(`PTM_OFF_CNT_LO);
		v = rd_d;
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, v);
		wr(`PTM_OFF_CLK_RUN, 8'h10);
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, v);
		wr(`PTM_OFF_CLK_RUN, 8'h98);
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, 32'h0);
		// pin edges: rising then falling selection, three of each
		for (int s = 6; s < 8; s++) begin
			wr(`PTM_OFF_CLK_RUN, 8'h00);
			wr(`PTM_OFF_CLK_RUN, {1'h0, 3'(s), 4'h8});
			pulses(3);
			rd(`PTM_OFF_CNT_LO);
			chk(rd_d, 32'h3);
		end
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_CLK_RUN, 8'h48);
		repeat (5) begin
			@(posedge clk);
			sub_clk_tick <= 1'h1;
			@(posedge clk);
			sub_clk_tick <= 1'h0;
		end
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, 32'h5);
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_CLK_RUN, 8'h28);
		high_clk_tick <= 1'h1;
		repeat (32) @(posedge clk);
		high_clk_tick <= 1'h0;
		rd(`PTM_OFF_CNT_LO);
		chk(rd_d, 32'h2);
		// timer stopped before every mode or function change
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_MODE_OUT, 8'h40);
		wr(`PTM_OFF_CLK_RUN, 8'h18);
		timer_io_pin_in <= 1'h1;
		repeat (8) @(posedge clk);
		rd(`PTM_OFF_CMPA_HI);
		chk(rd_d, 32'h0);
		wr(`PTM_OFF_CMPA_LO, 8'h10);
		wr(`PTM_OFF_CMPA_HI, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(`PTM_OFF_CLK_RUN, 8'h00);
			wr(`PTM_OFF_MODE_OUT, md[i]);
			wr(`PTM_OFF_CLK_RUN, 8'h18);
			po(pb[i]);
			repeat (30) @(posedge clk);
			po(pa[i]);
		end
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_MODE_OUT, 8'h01);
		wr(`PTM_OFF_CLK_RUN, 8'h18);
		repeat (40) @(posedge clk);
		rd(`PTM_OFF_CNT_LO);
		chk({31'h0, rd_d <= 32'h10}, 32'h1);
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_CMPP_LO, 8'h20);
		wr(`PTM_OFF_MODE_OUT, 8'hA8);
		wr(`PTM_OFF_CLK_RUN, 8'h18);
		repeat (8) @(posedge clk);
		repeat (64) begin
			@(posedge clk);
			h += int'(timer_io_pin_out);
		end
		chk(32'(h), 32'd32);
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_MODE_OUT, 8'hB8);
		wr(`PTM_OFF_CLK_RUN, 8'h18);
		po(2'h3);
		repeat (30) @(posedge clk);
		po(2'h2);
		rd(`PTM_OFF_CLK_RUN);
		chk(rd_d, 32'h10);
		wr(`PTM_OFF_CLK_RUN, 8'h00);
		wr(`PTM_OFF_MODE_OUT, 8'h9C);
		po(2'h2);
		wr(`PTM_OFF_MODE_OUT, 8'hCC);
		chk({31'h0, timer_io_pin_oe}, 32'h0);
		test_done();
	end
endmodule : ptm_timer_tb
`default_nettype wire
